// [dv/fbwp_host_model.sv]
// host side model: issues program and erase requests, watches array strobes
`timescale 1ns/1ps
module fbwp_host_model (
   input  wire logic        clk,        // system clock
   output      logic        req_valid,  // request present
   output      logic [7:0]  req_opcode, // command opcode
   output      logic [23:0] req_addr,   // target address
   input  wire logic        req_ready,  // request taken
   output      logic        wr_valid,   // data byte valid
   output      logic [7:0]  wr_byte,    // data byte
   output      logic        wr_last,    // final byte
   input  wire logic        wr_ready,   // byte taken
   input  wire logic        mem_we,     // array write pulse
   input  wire logic [23:0] mem_addr,   // array write address
   input  wire logic [7:0]  mem_wdata,  // array write data
   input  wire logic        erase_go,   // erase pulse
   input  wire logic [23:0] erase_lo,   // erase start
   input  wire logic [23:0] erase_hi,   // erase end
   input  wire logic        req_done    // request finished
);
   int          we_count;
   int          go_count;
   logic [23:0] first_addr;
   logic [23:0] last_addr;
   logic [7:0]  last_data;
   logic [23:0] lo_seen;
   logic [23:0] hi_seen;

   initial begin
      req_valid  = 1'b0;
      req_opcode = 8'h00;
      req_addr   = 24'h000000;
      wr_valid   = 1'b0;
      wr_byte    = 8'h00;
      wr_last    = 1'b0;
   end

   // ==========================================================
   // array strobe monitor
   always @(posedge clk) begin
      if (mem_we === 1'b1) begin
         if (we_count == 0) first_addr = mem_addr;
         we_count++;
         last_addr = mem_addr;
         last_data = mem_wdata;
      end
      if (erase_go === 1'b1) begin
         go_count++;
         lo_seen = erase_lo;
         hi_seen = erase_hi;
      end
   end

   // ==========================================================
   // one request, with n data bytes for a program
   task automatic run(input logic [7:0] op, input logic [23:0] a, input int n,
                      output logic done);
      int k;
      done = 1'b0;
      we_count = 0;
      go_count = 0;
      @(posedge clk);
      req_valid  <= 1'b1;
      req_opcode <= op;
      req_addr   <= a;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (req_ready === 1'b1) break;
      end
      req_valid <= 1'b0;
      for (int i = 0; i < n; i++) begin
         wr_valid <= 1'b1;
         wr_byte  <= 8'(i) ^ 8'h3c;
         wr_last  <= (i == n - 1);
         for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (wr_ready === 1'b1) break;
         end
      end
      wr_valid <= 1'b0;
      wr_last  <= 1'b0;
      // released data line must not keep showing the last byte
      wr_byte  <= ~wr_byte;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (req_done === 1'b1) break;
      end
      done = (req_done === 1'b1);
      req_opcode <= ~req_opcode;
      req_addr   <= ~req_addr;
      // let the monitor count this edge first
      #1;
   endtask : run
endmodule : fbwp_host_model

// [dv/flash_block_write_protect_test.sv]
// self-checking bench for the write protect block
`timescale 1ns/1ps
`include "fbwp_regs.svh"
module flash_block_write_protect_test;
   typedef struct packed {
      logic [5:0]  mode;
      logic [23:0] addr;
      logic        deny;
   } fbwp_row_t;

   logic        clk;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        req_valid, req_ready, wr_valid, wr_last, wr_ready, mem_we;
   logic        erase_go, req_done, req_denied;
   logic [7:0]  req_opcode, wr_byte, mem_wdata;
   logic [23:0] req_addr, mem_addr, erase_lo, erase_hi;
   int          fail_count;
   int          samples_checked;

   // mode = complement, unit size, top/bottom, span code
   fbwp_row_t rows [$] = '{
      '{6'h01, 24'h1f0000, 1'h1}, '{6'h01, 24'h1ef000, 1'h0}, '{6'h02, 24'h1e0000, 1'h1},
      '{6'h03, 24'h1bf000, 1'h0}, '{6'h04, 24'h180000, 1'h1}, '{6'h05, 24'h100000, 1'h1},
      '{6'h05, 24'h0ff000, 1'h0}, '{6'h06, 24'h000000, 1'h1}, '{6'h07, 24'h000000, 1'h1},
      '{6'h00, 24'h1ff000, 1'h0}, '{6'h09, 24'h00f000, 1'h1}, '{6'h09, 24'h010000, 1'h0},
      '{6'h0a, 24'h01f000, 1'h1}, '{6'h0b, 24'h03f000, 1'h1}, '{6'h0b, 24'h040000, 1'h0},
      '{6'h0c, 24'h07f000, 1'h1}, '{6'h0d, 24'h0ff000, 1'h1}, '{6'h0d, 24'h100000, 1'h0},
      '{6'h0e, 24'h1ff000, 1'h1}, '{6'h11, 24'h1ff000, 1'h1}, '{6'h11, 24'h1fe000, 1'h0},
      '{6'h13, 24'h1fc000, 1'h1}, '{6'h14, 24'h1f8000, 1'h1}, '{6'h15, 24'h1f7000, 1'h0},
      '{6'h16, 24'h000000, 1'h1}, '{6'h19, 24'h000000, 1'h1}, '{6'h19, 24'h001000, 1'h0},
      '{6'h1a, 24'h001000, 1'h1}, '{6'h1b, 24'h003000, 1'h1}, '{6'h1c, 24'h007000, 1'h1},
      '{6'h1d, 24'h008000, 1'h0}, '{6'h1f, 24'h1ff000, 1'h1}, '{6'h20, 24'h1ff000, 1'h1},
      '{6'h21, 24'h1ef000, 1'h1}, '{6'h21, 24'h1f0000, 1'h0}, '{6'h25, 24'h0ff000, 1'h1},
      '{6'h25, 24'h100000, 1'h0}, '{6'h26, 24'h000000, 1'h0}, '{6'h29, 24'h00f000, 1'h0},
      '{6'h29, 24'h010000, 1'h1}, '{6'h2d, 24'h100000, 1'h1}, '{6'h2d, 24'h0ff000, 1'h0},
      '{6'h2f, 24'h1ff000, 1'h0}, '{6'h30, 24'h000000, 1'h1}, '{6'h31, 24'h1fe000, 1'h1},
      '{6'h31, 24'h1ff000, 1'h0}, '{6'h34, 24'h1f7000, 1'h1}, '{6'h34, 24'h1f8000, 1'h0},
      '{6'h37, 24'h000000, 1'h0}, '{6'h39, 24'h001000, 1'h1}, '{6'h39, 24'h000000, 1'h0},
      '{6'h3c, 24'h008000, 1'h1}, '{6'h3c, 24'h007000, 1'h0}, '{6'h3e, 24'h1ff000, 1'h0}
   };

   fbwp_top dut_u (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_opcode(req_opcode),
      .req_addr(req_addr), .req_ready(req_ready), .wr_valid(wr_valid), .wr_byte(wr_byte),
      .wr_last(wr_last), .wr_ready(wr_ready), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .erase_go(erase_go), .erase_lo(erase_lo), .erase_hi(erase_hi),
      .req_done(req_done), .req_denied(req_denied));

   fbwp_host_model host_u (
      .clk(clk), .req_valid(req_valid), .req_opcode(req_opcode), .req_addr(req_addr),
      .req_ready(req_ready), .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_last(wr_last),
      .wr_ready(wr_ready), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .erase_go(erase_go), .erase_lo(erase_lo), .erase_hi(erase_hi), .req_done(req_done));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : reg_read

   task automatic erase_chk(input logic [7:0] op, input logic [23:0] a, input logic deny,
                            input logic [23:0] lo, input logic [23:0] hi);
      logic done;
      host_u.run(op, a, 0, done);
      check("done", done, 1'h1);
      check("denied", req_denied, deny);
      check("erases", host_u.go_count, deny ? 0 : 1);
      if (!deny) begin
         check("erase_lo", host_u.lo_seen, lo);
         check("erase_hi", host_u.hi_seen, hi);
      end
   endtask : erase_chk

   task automatic prog_chk(input logic [23:0] a, input int n, input logic deny,
                           input logic [23:0] last);
      logic done;
      host_u.run(`FBWP_OP_PROG, a, n, done);
      check("done", done, 1'h1);
      check("denied", req_denied, deny);
      check("writes", host_u.we_count, deny ? 0 : n);
      if (!deny) begin
         check("first_addr", host_u.first_addr, a);
         check("last_addr", host_u.last_addr, last);
         check("last_data", host_u.last_data, 8'(n - 1) ^ 8'h3c);
      end
   endtask : prog_chk

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   // watchdog, well past the run length
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] d;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("req_ready", req_ready, 1'h1);
      check("wr_ready", wr_ready, 1'h0);
      reg_read(`FBWP_OFS_SR1, d);
      check("sr1", d, 32'h0);
      reg_read(`FBWP_OFS_SR3, d);
      check("sr3", d, 32'h0);
      reg_read(8'h40, d);
      check("unmapped", d, 32'h0);
      reg_write(`FBWP_OFS_SR1, 32'hffffffff);
      reg_read(`FBWP_OFS_SR1, d);
      check("sr1 fields", d, 32'h7c);
      reg_read(`FBWP_OFS_LOCK_CMD, d);
      check("lock cmd", d, 32'h0);
      $display("test reset and registers done");

      foreach (rows[i]) begin
         reg_write(`FBWP_OFS_SR1, {25'h0, rows[i].mode[4:0], 2'h0});
         reg_write(`FBWP_OFS_SR2, {25'h0, rows[i].mode[5], 6'h0});
         erase_chk(`FBWP_OP_ERASE_4K, rows[i].addr, rows[i].deny, rows[i].addr,
                   rows[i].addr | 24'h000fff);
      end
      $display("test range table done");

      reg_write(`FBWP_OFS_SR1, 32'h0);
      reg_write(`FBWP_OFS_SR2, 32'h0);
      erase_chk(`FBWP_OP_ERASE_32K, 24'h1f9abc, 1'h0, 24'h1f8000, 24'h1fffff);
      erase_chk(`FBWP_OP_ERASE_64K, 24'h012345, 1'h0, 24'h010000, 24'h01ffff);
      erase_chk(`FBWP_OP_ERASE_CHIP, 24'h000000, 1'h0, 24'h000000, 24'h1fffff);
      erase_chk(8'h33, 24'h000000, 1'h1, 24'h0, 24'h0);
      reg_read(`FBWP_OFS_STATUS, d);
      check("status", d, 32'h2);
      prog_chk(24'h1ff0f0, 32, 1'h0, 24'h1ff00f);
      prog_chk(24'h1fe000, 256, 1'h0, 24'h1fe0ff);
      reg_write(`FBWP_OFS_SR1, 32'h44);
      prog_chk(24'h1ff0f0, 4, 1'h1, 24'h0);
      prog_chk(24'h1fefff, 1, 1'h0, 24'h1fefff);
      erase_chk(`FBWP_OP_ERASE_CHIP, 24'h000000, 1'h1, 24'h0, 24'h0);
      $display("test program and erase done");

      reg_write(`FBWP_OFS_SR1, 32'h1c);
      reg_write(`FBWP_OFS_SR3, 32'h4);
      erase_chk(`FBWP_OP_ERASE_4K, 24'h100000, 1'h1, 24'h0, 24'h0);
      reg_write(`FBWP_OFS_LOCK_CMD, 32'h2);
      erase_chk(`FBWP_OP_ERASE_4K, 24'h1ff000, 1'h0, 24'h1ff000, 24'h1fffff);
      reg_write(`FBWP_OFS_LOCK_ADDR, 32'h1fe000);
      reg_write(`FBWP_OFS_LOCK_CMD, 32'h1);
      erase_chk(`FBWP_OP_ERASE_4K, 24'h1fe000, 1'h1, 24'h0, 24'h0);
      erase_chk(`FBWP_OP_ERASE_4K, 24'h1fd000, 1'h0, 24'h1fd000, 24'h1fdfff);
      reg_write(`FBWP_OFS_LOCK_CMD, 32'h3);
      erase_chk(`FBWP_OP_ERASE_4K, 24'h080000, 1'h1, 24'h0, 24'h0);
      $display("test lock scheme done");

      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      reg_read(`FBWP_OFS_SR1, d);
      check("sr1 after reset", d, 32'h0);
      reg_read(`FBWP_OFS_SR3, d);
      check("sr3 after reset", d, 32'h0);
      erase_chk(`FBWP_OP_ERASE_4K, 24'h1ff000, 1'h0, 24'h1ff000, 24'h1fffff);
      $display("test second reset done");
      stop_test();
   end
endmodule : flash_block_write_protect_test

// [rtl/fbwp_dec_if.sv]
// protection fields in, decoded protected interval out
`timescale 1ns/1ps
interface fbwp_dec_if;
   logic        complement_flag;
   logic        protect_unit_size;
   logic        top_bottom_select;
   logic [2:0]  protect_span_code;
   logic        prot_none;
   logic [23:0] prot_lo;
   logic [23:0] prot_hi;
   modport ctrl (output complement_flag, protect_unit_size, top_bottom_select,
                 protect_span_code, input prot_none, prot_lo, prot_hi);
   modport dec  (input complement_flag, protect_unit_size, top_bottom_select,
                 protect_span_code, output prot_none, prot_lo, prot_hi);
endinterface : fbwp_dec_if

// [rtl/fbwp_pkg.sv]
// types shared by the write protect block
package fbwp_pkg;
   typedef enum logic [1:0] {
      FBWP_IDLE  = 2'b00,
      FBWP_CHECK = 2'b01,
      FBWP_XFER  = 2'b11,
      FBWP_DONE  = 2'b10
   } fbwp_state_t;
endpackage : fbwp_pkg

// [rtl/fbwp_range.sv]
// standard range decoder: fields to one protected interval
`timescale 1ns/1ps
`include "fbwp_regs.svh"
module fbwp_range import fbwp_pkg::*; (
   fbwp_dec_if.dec d   // fields in, interval out
);
   logic [2:0]  shamt;
   logic [23:0] len;
   logic        raw_none;
   logic        raw_all;

   // ==============================================================
   // span length
   always_comb begin
      raw_none = (d.protect_span_code == 3'h0);
      raw_all  = (d.protect_span_code[2:1] == 2'b11);
      // 4k units stop doubling at 32 KB, so codes 4 and 5 match
      if (d.protect_unit_size && d.protect_span_code[2])
         shamt = 3'h3;
      else
         shamt = d.protect_span_code - 3'h1;
      len = (d.protect_unit_size ? `FBWP_UNIT_4K : `FBWP_UNIT_64K) << shamt;
   end

   // ==============================================================
   // interval; ends default to zero and the true array top
   always_comb begin
      d.prot_none = 1'b0;
      d.prot_lo   = 24'h000000;
      d.prot_hi   = `FBWP_ARRAY_TOP;
      if (!d.complement_flag) begin
         if (raw_none)
            d.prot_none = 1'b1;
         else if (!raw_all) begin
            if (d.top_bottom_select)
               d.prot_hi = len - 24'h1;
            else
               d.prot_lo = `FBWP_ARRAY_SIZE - len;
         end
      end else begin
         // complement of an anchored span is anchored at the other end
         if (raw_all)
            d.prot_none = 1'b1;
         else if (!raw_none) begin
            if (d.top_bottom_select)
               d.prot_lo = len;
            else
               d.prot_hi = `FBWP_ARRAY_TOP - len;
         end
      end
   end
endmodule : fbwp_range

// [rtl/fbwp_regs.svh]
// register offsets, field positions, reset values and array constants
`ifndef FBWP_REGS_SVH
`define FBWP_REGS_SVH

// ==============================================================
// register byte offsets
`define FBWP_OFS_SR1        8'h00
`define FBWP_OFS_SR2        8'h04
`define FBWP_OFS_SR3        8'h08
`define FBWP_OFS_LOCK_ADDR  8'h0c
`define FBWP_OFS_LOCK_CMD   8'h10
`define FBWP_OFS_STATUS     8'h14

// ==============================================================
// field positions
`define FBWP_SR1_UNIT_BIT   6
`define FBWP_SR1_TB_BIT     5
`define FBWP_SR1_SPAN_HI    4
`define FBWP_SR1_SPAN_LO    2
`define FBWP_SR2_CMP_BIT    6
`define FBWP_SR3_SCHEME_BIT 2
`define FBWP_ST_BUSY_BIT    0
`define FBWP_ST_DENY_BIT    1

// lock command codes, written to bits 1:0 of the lock command register
`define FBWP_LCMD_UNLOCK    2'h0
`define FBWP_LCMD_LOCK      2'h1
`define FBWP_LCMD_GUNLOCK   2'h2
`define FBWP_LCMD_GLOCK     2'h3

// ==============================================================
// reset values
`define FBWP_RST_SR1        5'h00
`define FBWP_RST_CMP        1'b0
`define FBWP_RST_SCHEME     1'b0
`define FBWP_RST_LOCKS      64'hffff_ffff_ffff_ffff

// ==============================================================
// array geometry and opcodes
`define FBWP_ARRAY_TOP      24'h1fffff
`define FBWP_ARRAY_SIZE     24'h200000
`define FBWP_UNIT_4K        24'h001000
`define FBWP_UNIT_64K       24'h010000
`define FBWP_MASK_PAGE      24'h0000ff
`define FBWP_MASK_4K        24'h000fff
`define FBWP_MASK_32K       24'h007fff
`define FBWP_MASK_64K       24'h00ffff
`define FBWP_OP_PROG        8'h02
`define FBWP_OP_ERASE_4K    8'h20
`define FBWP_OP_ERASE_32K   8'h52
`define FBWP_OP_ERASE_64K   8'hd8
`define FBWP_OP_ERASE_CHIP  8'hc7

`endif

// [rtl/fbwp_top.sv]
// write protect block: status fields, lock bits, program and erase gate
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "fbwp_regs.svh"

// What this block does
// - each 4 KB block holds sixteen 256-byte pages on 256-byte boundaries
// - page program 02h writes 1 to 256 bytes inside one page
// - 4 KB granularity; whole-array and per-block lock beside range scheme
// - scheme select 0 uses complement, unit, top/bottom and span fields
// - complement flag inverts the decoded range
// - unit size 0 selects 64 KB units, 1 selects 4 KB units
// - top/bottom 0 anchors at array top, 1 at address zero
// - three-bit span code chooses none, part or whole array
// - protected addresses refuse program and erase; reads unaffected
// - 64 KB top: codes double from 1F0000h; 110/111 whole array
// - 64 KB bottom: codes double from 00FFFFh; 110/111 whole array
// - 4 KB top: 4, 8, 16 KB then 32 KB twice; 110/111 all
// - 4 KB bottom: up to 0FFFh, 1FFFh, 3FFFh, then 7FFFh twice
// - complement with 64 KB units protects the opposite range
// - complement with 4 KB units protects the opposite range
// - addresses outside the decoded range stay open
// - scheme select 1 uses per-block lock bits instead
module fbwp_top import fbwp_pkg::*; (
   input  wire logic        clk,        // 25 MHz clock
   input  wire logic        rst,        // synchronous reset, high
   input  wire logic [7:0]  reg_addr,   // register byte address
   input  wire logic [31:0] reg_wdata,  // register write data
   input  wire logic        reg_wr,     // register write strobe
   input  wire logic        reg_rd,     // register read strobe
   output      logic [31:0] reg_rdata,  // read data, cycle after reg_rd
   input  wire logic        req_valid,  // program or erase request
   input  wire logic [7:0]  req_opcode, // command opcode
   input  wire logic [23:0] req_addr,   // target address
   output      logic        req_ready,  // request taken when high with valid
   input  wire logic        wr_valid,   // program data byte valid
   input  wire logic [7:0]  wr_byte,    // program data byte
   input  wire logic        wr_last,    // final byte of the program
   output      logic        wr_ready,   // byte taken when high with valid
   output      logic        mem_we,     // array byte write pulse
   output      logic [23:0] mem_addr,   // array byte address
   output      logic [7:0]  mem_wdata,  // array byte data
   output      logic        erase_go,   // array erase pulse
   output      logic [23:0] erase_lo,   // first erased address
   output      logic [23:0] erase_hi,   // last erased address
   output      logic        req_done,   // request finished pulse
   output      logic        req_denied  // request was refused, stands to next
);
   fbwp_dec_if dec ();

   fbwp_state_t state;
   fbwp_state_t next_state;
   logic [4:0]  sr1;
   logic        cmp_bit;
   logic        scheme_select;
   logic [23:0] lock_addr;
   logic [63:0] lock_bits;
   logic        is_prog;
   logic        op_known;
   logic [23:0] mask;
   logic [23:0] rg_lo;
   logic [23:0] rg_hi;
   logic        blocked;
   logic [7:0]  page_ofs;
   logic        rd_hit;
   logic [31:0] rd_val;

   // ==============================================================
   // functions
   function automatic logic [23:0] op_mask(input logic [7:0] op);
      unique case (op)
         `FBWP_OP_PROG:       op_mask = `FBWP_MASK_PAGE;
         `FBWP_OP_ERASE_4K:   op_mask = `FBWP_MASK_4K;
         `FBWP_OP_ERASE_32K:  op_mask = `FBWP_MASK_32K;
         `FBWP_OP_ERASE_64K:  op_mask = `FBWP_MASK_64K;
         default:             op_mask = `FBWP_ARRAY_TOP;
      endcase
   endfunction : op_mask

   // lock bit index: 4 KB bits in first and last 64 KB, else one per 64 KB
   function automatic logic [5:0] lock_index(input logic [23:0] a);
      if (a[20:16] == 5'h00)
         lock_index = {2'b00, a[15:12]};
      else if (a[20:16] == 5'h1f)
         lock_index = {2'b01, a[15:12]};
      else
         lock_index = {1'b1, a[20:16]};
   endfunction : lock_index

   function automatic logic lock_hit(input logic [63:0] lk, input logic [23:0] s,
                                     input logic [23:0] e);
      logic [23:0] b;
      logic [23:0] t;
      lock_hit = 1'b0;
      for (int i = 0; i < 64; i++) begin
         if (i < 16) begin
            b = 24'(i) << 12;
            t = b | `FBWP_MASK_4K;
         end else if (i < 32) begin
            b = 24'h1f0000 | (24'(i - 16) << 12);
            t = b | `FBWP_MASK_4K;
         end else begin
            b = 24'(i - 32) << 16;
            t = b | `FBWP_MASK_64K;
         end
         // bits 32 and 63 fall inside the 4 KB-split blocks and are unused
         if (i != 32 && i != 63 && lk[i] && s <= t && e >= b)
            lock_hit = 1'b1;
      end
   endfunction : lock_hit

   // ==============================================================
   // range decoder
   assign dec.complement_flag   = cmp_bit;
   assign dec.protect_unit_size = sr1[`FBWP_SR1_UNIT_BIT - 2];
   assign dec.top_bottom_select = sr1[`FBWP_SR1_TB_BIT - 2];
   assign dec.protect_span_code = sr1[2:0];

   fbwp_range u_range (
      .d (dec.dec)
   );

   // ==============================================================
   // target region and protection verdict
   always_comb begin
      is_prog  = (req_opcode == `FBWP_OP_PROG);
      op_known = is_prog || req_opcode == `FBWP_OP_ERASE_4K ||
                 req_opcode == `FBWP_OP_ERASE_32K || req_opcode == `FBWP_OP_ERASE_64K ||
                 req_opcode == `FBWP_OP_ERASE_CHIP;
      mask     = op_mask(req_opcode);
      rg_lo    = req_addr & `FBWP_ARRAY_TOP & ~mask;
      rg_hi    = rg_lo | mask;
      if (scheme_select)
         blocked = lock_hit(lock_bits, rg_lo, rg_hi);
      else
         blocked = !dec.prot_none && rg_lo <= dec.prot_hi &&
                   rg_hi >= dec.prot_lo;
   end

   // ==============================================================
   // request sequencer
   assign req_ready = (state == FBWP_IDLE);
   assign wr_ready  = (state == FBWP_XFER) && is_prog;

   always_comb begin
      next_state = state;
      unique case (state)
         FBWP_IDLE:  if (req_valid) next_state = FBWP_CHECK;
         FBWP_CHECK: next_state = FBWP_XFER;
         FBWP_XFER:  if (!is_prog || (wr_valid && wr_last)) next_state = FBWP_DONE;
         FBWP_DONE:  next_state = FBWP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst)
         state <= FBWP_IDLE;
      else
         state <= next_state;
   end

   // verdict latched before the array is touched
   always_ff @(posedge clk) begin
      if (rst)
         req_denied <= 1'b0;
      else if (state == FBWP_CHECK)
         req_denied <= blocked || !op_known;
   end

   // the host holds opcode and address from request to done
   always_ff @(posedge clk) begin
      if (rst)
         page_ofs <= 8'h00;
      else if (state == FBWP_CHECK)
         page_ofs <= req_addr[7:0];
      else if (wr_valid && wr_ready)
         page_ofs <= page_ofs + 8'h01;
   end

   // past the page end the offset wraps, never crossing into the next page
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_we    <= 1'b0;
         mem_addr  <= 24'h000000;
         mem_wdata <= 8'h00;
      end else begin
         mem_we <= wr_valid && wr_ready && !req_denied;
         if (wr_valid && wr_ready) begin
            mem_addr  <= {rg_lo[23:8], page_ofs};
            mem_wdata <= wr_byte;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         erase_go <= 1'b0;
         erase_lo <= 24'h000000;
         erase_hi <= 24'h000000;
      end else begin
         erase_go <= (state == FBWP_XFER) && !is_prog && !req_denied;
         if (state == FBWP_XFER && !is_prog) begin
            erase_lo <= rg_lo;
            erase_hi <= rg_hi;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         req_done <= 1'b0;
      else
         req_done <= (next_state == FBWP_DONE) && (state == FBWP_XFER);
   end

   // ==============================================================
   // status fields
   always_ff @(posedge clk) begin
      if (rst) begin
         sr1           <= `FBWP_RST_SR1;
         cmp_bit       <= `FBWP_RST_CMP;
         scheme_select <= `FBWP_RST_SCHEME;
         lock_addr     <= 24'h000000;
      end else if (reg_wr) begin
         if (reg_addr == `FBWP_OFS_SR1)
            sr1 <= reg_wdata[`FBWP_SR1_UNIT_BIT:`FBWP_SR1_SPAN_LO];
         if (reg_addr == `FBWP_OFS_SR2)
            cmp_bit <= reg_wdata[`FBWP_SR2_CMP_BIT];
         if (reg_addr == `FBWP_OFS_SR3)
            scheme_select <= reg_wdata[`FBWP_SR3_SCHEME_BIT];
         if (reg_addr == `FBWP_OFS_LOCK_ADDR)
            lock_addr <= reg_wdata[23:0];
      end
   end

   // all blocks come up locked
   always_ff @(posedge clk) begin
      if (rst)
         lock_bits <= `FBWP_RST_LOCKS;
      else if (reg_wr && reg_addr == `FBWP_OFS_LOCK_CMD) begin
         unique case (reg_wdata[1:0])
            `FBWP_LCMD_UNLOCK:  lock_bits[lock_index(lock_addr)] <= 1'b0;
            `FBWP_LCMD_LOCK:    lock_bits[lock_index(lock_addr)] <= 1'b1;
            `FBWP_LCMD_GUNLOCK: lock_bits <= 64'h0;
            `FBWP_LCMD_GLOCK:   lock_bits <= `FBWP_RST_LOCKS;
         endcase
      end
   end

   // ==============================================================
   // register read port
   always_comb begin
      rd_val = 32'h0;
      unique case (reg_addr)
         `FBWP_OFS_SR1:       rd_val[`FBWP_SR1_UNIT_BIT:`FBWP_SR1_SPAN_LO] = sr1;
         `FBWP_OFS_SR2:       rd_val[`FBWP_SR2_CMP_BIT] = cmp_bit;
         `FBWP_OFS_SR3:       rd_val[`FBWP_SR3_SCHEME_BIT] = scheme_select;
         `FBWP_OFS_LOCK_ADDR: rd_val[23:0] = lock_addr;
         `FBWP_OFS_STATUS: begin
            rd_val[`FBWP_ST_BUSY_BIT] = (state != FBWP_IDLE);
            rd_val[`FBWP_ST_DENY_BIT] = req_denied;
         end
         default:             rd_val = 32'h0;
      endcase
   end

   assign rd_hit = reg_rd;

   always_ff @(posedge clk) begin
      if (rst)
         reg_rdata <= 32'h0;
      else if (rd_hit)
         reg_rdata <= rd_val;
      else
         reg_rdata <= 32'h0;
   end

   // ==============================================================
   // checks
   no_prot_write_a:
   assert property (@(posedge clk) disable iff (rst)
      mem_we |-> $past(req_denied) == 1'b0 && !req_denied)
      else $error("byte written to a refused target");

   page_bound_a:
   assert property (@(posedge clk) disable iff (rst)
      mem_we |-> mem_addr[23:8] == $past(rg_lo[23:8]))
      else $error("program left its page");

   erase_gate_a:
   assert property (@(posedge clk) disable iff (rst)
      erase_go |-> !req_denied && req_done)
      else $error("erase issued on refused target or not finished");

   none_code_a:
   assert property (@(posedge clk) disable iff (rst)
      (!cmp_bit && sr1[2:0] == 3'h0) |-> dec.prot_none)
      else $error("span code zero protects something");

   top_64k_a:
   assert property (@(posedge clk) disable iff (rst)
      (!cmp_bit && sr1 == 5'b00001) |-> dec.prot_lo == 24'h1f0000 &&
      dec.prot_hi == 24'h1fffff)
      else $error("top 64 KB decode wrong");

   bot_4k_a:
   assert property (@(posedge clk) disable iff (rst)
      (!cmp_bit && sr1 == 5'b11101) |-> dec.prot_lo == 24'h0 && dec.prot_hi == 24'h007fff)
      else $error("bottom 32 KB decode wrong");

   comp_top_a:
   assert property (@(posedge clk) disable iff (rst)
      (cmp_bit && sr1 == 5'b10001) |-> dec.prot_lo == 24'h0 && dec.prot_hi == 24'h1fefff)
      else $error("complement top decode wrong");

   comp_all_a:
   assert property (@(posedge clk) disable iff (rst)
      (cmp_bit && sr1[2:0] == 3'h0) |-> !dec.prot_none && dec.prot_lo == 24'h0 &&
      dec.prot_hi == `FBWP_ARRAY_TOP)
      else $error("complement of none not whole array");

   lock_deny_a:
   assert property (@(posedge clk) disable iff (rst)
      (state == FBWP_CHECK && scheme_select && lock_bits == `FBWP_RST_LOCKS)
      |=> req_denied [*2])
      else $error("locked array accepted a request");

   open_ok_a:
   assert property (@(posedge clk) disable iff (rst)
      (state == FBWP_CHECK && op_known && !scheme_select && dec.prot_none)
      |=> !req_denied)
      else $error("unprotected target refused");
endmodule : fbwp_top
